// ### logic/tpslc_map.svh
// Constants of the transmit pulse shaper and line control block
`ifndef TPSLC_MAP_SVH
`define TPSLC_MAP_SVH

// Default amplitude scale per build-out template
`define TPSLC_SCALE_0DB 6'h36
`define TPSLC_SCALE_7P5DB 6'h11
`define TPSLC_SCALE_15DB 6'h08
`define TPSLC_SCALE_22P5DB 6'h04

// Pulse template codes
`define TPSLC_TPL_E1_75 4'h0
`define TPSLC_TPL_E1_120 4'h1
`define TPSLC_TPL_J1 4'h7
`define TPSLC_TPL_LBO_0DB 4'h8
`define TPSLC_TPL_LBO_22P5DB 4'hB
`define TPSLC_TPL_RESET 4'h8
`define TPSLC_LBO_PREFIX 2'h2

// Termination field layout and impedance codes
`define TPSLC_TERM_EXT_BIT 2
`define TPSLC_IMP_E1_75 2'h0
`define TPSLC_IMP_E1_120 2'h1
`define TPSLC_IMP_T1_100 2'h2
`define TPSLC_IMP_J1_110 2'h3

// Pattern pin code that powers the transmitter down
`define TPSLC_PATT_PWRDN 2'h3

// Sample grid: 16 samples per interval, 4 intervals
`define TPSLC_LAST_IDX 6'h3F

// Timing
`define TPSLC_CLK_PERIOD_NS 25
`define TPSLC_LOSS_TIME_NS 3200
`define TPSLC_LOSS_CYC (`TPSLC_LOSS_TIME_NS / `TPSLC_CLK_PERIOD_NS)
`define TPSLC_RST_HOLD_NS 400
`define TPSLC_RST_HOLD_CYC \
  ((`TPSLC_RST_HOLD_NS + `TPSLC_CLK_PERIOD_NS - 1) / `TPSLC_CLK_PERIOD_NS)

`endif

// ### logic/tpslc_pkg.sv
// Types of the transmit pulse shaper and line control block
`default_nettype none
package tpslc_pkg;

  typedef enum logic [0:0] {seq_idle, seq_play} tpslc_seq_type;

  typedef struct packed {
    logic [8:0] meta;
    logic [8:0] stable;
  } tpslc_sync_type;

  typedef struct packed {
    logic meta;
    logic stable;
    logic prev;
    logic [7:0] count;
    logic lost;
  } tpslc_cdet_type;

  typedef struct packed {
    logic [5:0] scale;
    logic [3:0] tpl;
    tpslc_seq_type seq;
    logic [5:0] idx;
    logic [10:0] dac;
    logic oe;
    logic [4:0] hold;
    logic pwr_dn;
    logic term_int;
    logic [1:0] term_imp;
    logic rx_ext;
    logic cfg_err;
  } tpslc_state_type;

endpackage
`default_nettype wire

// ### logic/tpslc_pin_sync.sv
// Two-stage synchroniser for the control pins
`default_nettype none
module tpslc_pin_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [8:0] pins_async,
  output logic [8:0] pins_sync
);

  tpslc_pkg::tpslc_sync_type state_reg;
  tpslc_pkg::tpslc_sync_type state_next;

  // First stage feeds only the second
  always_comb begin
    state_next = state_reg;
    state_next.meta = pins_async;
    state_next.stable = state_reg.meta;
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pins_sync = state_reg.stable;

endmodule
`default_nettype wire

// ### logic/tpslc_clk_loss.sv
// Loss detector for a clock that arrives on a pin
`include "tpslc_map.svh"
`default_nettype none
module tpslc_clk_loss (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_pin,
  output logic lost
);

  localparam logic [7:0] LOSS_LIMIT = 8'(`TPSLC_LOSS_CYC - 1);

  tpslc_pkg::tpslc_cdet_type state_reg;
  tpslc_pkg::tpslc_cdet_type state_next;
  logic edge_seen;

  // Any edge seen after synchronising restarts the count
  assign edge_seen = state_reg.stable ^ state_reg.prev;

  // Count reference cycles without an edge; release on the next edge
  always_comb begin
    state_next = state_reg;
    state_next.meta = clk_pin;
    state_next.stable = state_reg.meta;
    state_next.prev = state_reg.stable;
    if (edge_seen) begin
      state_next.count = 8'h00;
      state_next.lost = 1'b0;
    end else if (state_reg.count == LOSS_LIMIT) begin
      state_next.lost = 1'b1;
    end else begin
      state_next.count = state_reg.count + 8'h01;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign lost = state_reg.lost;

endmodule
`default_nettype wire

// ### logic/tpslc_top.sv
// Transmit pulse shaper, amplitude scaling and line driver control
`include "tpslc_map.svh"
`default_nettype none
module tpslc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hw_mode,
  input wire logic tx_high_impedance,
  input wire logic termination_mode_pin,
  input wire logic [1:0] pattern_select_pins,
  input wire logic [3:0] pulse_template_pins,
  input wire logic mclk_in,
  input wire logic tx_clock_in,
  input wire logic [3:0] pulse_template_select,
  input wire logic [2:0] tx_term_select,
  input wire logic chan_hiz_bit,
  input wire logic tx_power_off_bit,
  input wire logic scale_write,
  input wire logic [5:0] scale_wdata,
  input wire logic sw_reset,
  input wire logic remote_loopback,
  input wire logic pattern_from_mclk,
  input wire logic pulse_start,
  input wire logic sample_tick,
  output logic [5:0] amplitude_scale,
  output logic [3:0] active_template,
  output logic lbo_active,
  output logic [10:0] dac_code,
  output logic tx_line_oe,
  output logic tx_power_down,
  output logic tx_term_internal,
  output logic [1:0] tx_term_impedance,
  output logic rx_term_external,
  output logic term_config_error,
  output logic mclk_lost,
  output logic tclk_lost
);

  localparam logic [4:0] HOLD_CYC = 5'(`TPSLC_RST_HOLD_CYC);
  tpslc_pkg::tpslc_state_type state_reg;
  tpslc_pkg::tpslc_state_type state_next;
  logic [8:0] pins_sync;
  logic hw_s;
  logic ghiz_s;
  logic term_pin_s;
  logic [1:0] patt_s;
  logic [3:0] tpl_pins_s;
  logic [3:0] tpl_now;
  logic is_lbo;
  logic t1j1_mode;
  logic float_req;
  logic clk_fault;
  // Default scale of a build-out template
  function automatic logic [5:0] tpslc_def_scale(input logic [1:0] sel);
    logic [5:0] r;
    case (sel)
      2'h0: r = `TPSLC_SCALE_0DB;
      2'h1: r = `TPSLC_SCALE_7P5DB;
      2'h2: r = `TPSLC_SCALE_15DB;
      2'h3: r = `TPSLC_SCALE_22P5DB;
      default: r = `TPSLC_SCALE_0DB;
    endcase
    return r;
  endfunction
  // One sample row: four intervals packed first to last
  function automatic logic [27:0] tpslc_row(input logic [5:0] key);
    logic [27:0] r;
    case (key)
      // 0 dB
      6'h00: r = {7'h17, 7'h42, 7'h00, 7'h00};
      6'h01: r = {7'h27, 7'h41, 7'h00, 7'h00};
      6'h02: r = {7'h27, 7'h00, 7'h00, 7'h00};
      6'h03: r = {7'h26, 7'h00, 7'h00, 7'h00};
      6'h04: r = {7'h25, 7'h00, 7'h00, 7'h00};
      6'h05: r = {7'h25, 7'h00, 7'h00, 7'h00};
      6'h06: r = {7'h25, 7'h00, 7'h00, 7'h00};
      6'h07: r = {7'h24, 7'h00, 7'h00, 7'h00};
      6'h08: r = {7'h23, 7'h00, 7'h00, 7'h00};
      6'h09: r = {7'h4A, 7'h00, 7'h00, 7'h00};
      6'h0A: r = {7'h4A, 7'h00, 7'h00, 7'h00};
      6'h0B: r = {7'h49, 7'h00, 7'h00, 7'h00};
      6'h0C: r = {7'h47, 7'h00, 7'h00, 7'h00};
      6'h0D: r = {7'h45, 7'h00, 7'h00, 7'h00};
      6'h0E: r = {7'h44, 7'h00, 7'h00, 7'h00};
      6'h0F: r = {7'h43, 7'h00, 7'h00, 7'h00};
      // 7.5 dB
      6'h10: r = {7'h00, 7'h14, 7'h02, 7'h00};
      6'h11: r = {7'h02, 7'h12, 7'h02, 7'h00};
      6'h12: r = {7'h09, 7'h10, 7'h02, 7'h00};
      6'h13: r = {7'h13, 7'h0E, 7'h02, 7'h00};
      6'h14: r = {7'h1D, 7'h0C, 7'h02, 7'h00};
      6'h15: r = {7'h25, 7'h0B, 7'h01, 7'h00};
      6'h16: r = {7'h2B, 7'h0A, 7'h01, 7'h00};
      6'h17: r = {7'h31, 7'h09, 7'h01, 7'h00};
      6'h18: r = {7'h36, 7'h08, 7'h01, 7'h00};
      6'h19: r = {7'h3A, 7'h07, 7'h01, 7'h00};
      6'h1A: r = {7'h39, 7'h06, 7'h01, 7'h00};
      6'h1B: r = {7'h30, 7'h05, 7'h01, 7'h00};
      6'h1C: r = {7'h28, 7'h04, 7'h00, 7'h00};
      6'h1D: r = {7'h20, 7'h04, 7'h00, 7'h00};
      6'h1E: r = {7'h1A, 7'h03, 7'h00, 7'h00};
      6'h1F: r = {7'h17, 7'h03, 7'h00, 7'h00};
      // 15 dB
      6'h20: r = {7'h00, 7'h35, 7'h0F, 7'h03};
      6'h21: r = {7'h00, 7'h33, 7'h0D, 7'h02};
      6'h22: r = {7'h00, 7'h30, 7'h0C, 7'h02};
      6'h23: r = {7'h01, 7'h2D, 7'h0B, 7'h02};
      6'h24: r = {7'h04, 7'h2A, 7'h0A, 7'h02};
      6'h25: r = {7'h08, 7'h27, 7'h09, 7'h01};
      6'h26: r = {7'h0E, 7'h24, 7'h08, 7'h01};
      6'h27: r = {7'h14, 7'h21, 7'h07, 7'h01};
      6'h28: r = {7'h1B, 7'h1E, 7'h06, 7'h01};
      6'h29: r = {7'h22, 7'h1C, 7'h06, 7'h01};
      6'h2A: r = {7'h2A, 7'h1A, 7'h05, 7'h01};
      6'h2B: r = {7'h30, 7'h17, 7'h05, 7'h01};
      6'h2C: r = {7'h35, 7'h15, 7'h04, 7'h01};
      6'h2D: r = {7'h37, 7'h14, 7'h04, 7'h00};
      6'h2E: r = {7'h38, 7'h12, 7'h03, 7'h00};
      6'h2F: r = {7'h37, 7'h10, 7'h03, 7'h00};
      // 22.5 dB
      6'h30: r = {7'h00, 7'h2C, 7'h1E, 7'h08};
      6'h31: r = {7'h00, 7'h2E, 7'h1C, 7'h07};
      6'h32: r = {7'h00, 7'h30, 7'h1A, 7'h06};
      6'h33: r = {7'h00, 7'h31, 7'h18, 7'h05};
      6'h34: r = {7'h01, 7'h32, 7'h17, 7'h05};
      6'h35: r = {7'h03, 7'h32, 7'h15, 7'h04};
      6'h36: r = {7'h07, 7'h32, 7'h14, 7'h04};
      6'h37: r = {7'h0B, 7'h31, 7'h13, 7'h03};
      6'h38: r = {7'h0F, 7'h30, 7'h11, 7'h03};
      6'h39: r = {7'h15, 7'h2E, 7'h10, 7'h02};
      6'h3A: r = {7'h19, 7'h2C, 7'h0F, 7'h02};
      6'h3B: r = {7'h1C, 7'h29, 7'h0E, 7'h02};
      6'h3C: r = {7'h20, 7'h27, 7'h0D, 7'h01};
      6'h3D: r = {7'h23, 7'h24, 7'h0C, 7'h01};
      6'h3E: r = {7'h27, 7'h22, 7'h0A, 7'h01};
      6'h3F: r = {7'h2A, 7'h20, 7'h09, 7'h01};
      default: r = 28'h0000000;
    endcase
    return r;
  endfunction
  // Sample at grid index: interval in the high bits, sample in the low
  function automatic logic [6:0] tpslc_sample(input logic [1:0] sel,
                                              input logic [5:0] idx);
    logic [27:0] row;
    logic [6:0] s;
    row = tpslc_row({sel, idx[3:0]});
    case (idx[5:4])
      2'h0: s = row[27:21];
      2'h1: s = row[20:14];
      2'h2: s = row[13:7];
      2'h3: s = row[6:0];
      default: s = 7'h00;
    endcase
    return s;
  endfunction
  // Scale a sample by current over default scale
  function automatic logic [10:0] tpslc_scaled(input logic [6:0] smp,
                                               input logic [5:0] scale,
                                               input logic [1:0] sel);
    logic [12:0] prod;
    logic [12:0] div;
    prod = 13'(smp * scale);
    div = 13'(tpslc_def_scale(sel));
    return 11'(prod / div);
  endfunction
  // Impedance code implied by a template code in hardware mode
  function automatic logic [1:0] tpslc_imp(input logic [3:0] tpl);
    logic [1:0] r;
    case (tpl)
      `TPSLC_TPL_E1_75: r = `TPSLC_IMP_E1_75;
      `TPSLC_TPL_E1_120: r = `TPSLC_IMP_E1_120;
      `TPSLC_TPL_J1: r = `TPSLC_IMP_J1_110;
      default: r = `TPSLC_IMP_T1_100;
    endcase
    return r;
  endfunction
  // Pins from outside pass two flip-flops first
  tpslc_pin_sync u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pins_async({hw_mode, tx_high_impedance, termination_mode_pin,
                 pattern_select_pins, pulse_template_pins}),
    .pins_sync(pins_sync)
  );

  // Master and transmit clock supervision
  tpslc_clk_loss u_mclk_loss (
    .clk(clk),
    .rst_n(rst_n),
    .clk_pin(mclk_in),
    .lost(mclk_lost)
  );

  tpslc_clk_loss u_tclk_loss (
    .clk(clk),
    .rst_n(rst_n),
    .clk_pin(tx_clock_in),
    .lost(tclk_lost)
  );

  assign hw_s = pins_sync[8];
  assign ghiz_s = pins_sync[7];
  assign term_pin_s = pins_sync[6];
  assign patt_s = pins_sync[5:4];
  assign tpl_pins_s = pins_sync[3:0];

  // Template from pins or software; codes 8 to B are build-outs
  assign tpl_now = hw_s ? tpl_pins_s : pulse_template_select;
  assign is_lbo = (tpl_now[3:2] == `TPSLC_LBO_PREFIX);
  assign t1j1_mode = (tpl_now != `TPSLC_TPL_E1_75) &&
                     (tpl_now != `TPSLC_TPL_E1_120);

  // Transmit clock loss is excused in remote loop or master-clock pattern
  assign clk_fault = mclk_lost ||
                     (tclk_lost && !(remote_loopback || pattern_from_mclk));

  // Every reason to float the line outputs
  assign float_req = ghiz_s || (!hw_s && chan_hiz_bit) || clk_fault || sw_reset ||
                     (state_reg.hold != 5'h00) ||
                     (hw_s ? (patt_s == `TPSLC_PATT_PWRDN) : tx_power_off_bit);

  // Next state of scale, sequencer, line control and termination
  always_comb begin
    state_next = state_reg;
    state_next.tpl = tpl_now;
    // Change to a build-out template reloads the default scale
    if (is_lbo && (tpl_now != state_reg.tpl)) begin
      state_next.scale = tpslc_def_scale(tpl_now[1:0]);
    end
    if (scale_write) begin
      state_next.scale = scale_wdata;
    end
    // Pulse playback over the 64-sample grid
    case (state_reg.seq)
      tpslc_pkg::seq_idle: begin
        if (pulse_start && is_lbo) begin
          state_next.seq = tpslc_pkg::seq_play;
          state_next.idx = 6'h00;
        end
      end
      tpslc_pkg::seq_play: begin
        if (!is_lbo) begin
          state_next.seq = tpslc_pkg::seq_idle;
        end else if (pulse_start) begin
          state_next.idx = 6'h00;
        end else if (sample_tick) begin
          if (state_reg.idx == `TPSLC_LAST_IDX) begin
            state_next.seq = tpslc_pkg::seq_idle;
          end else begin
            state_next.idx = state_reg.idx + 6'h01;
          end
        end
      end
      default: state_next.seq = tpslc_pkg::seq_idle;
    endcase
    if (state_reg.seq == tpslc_pkg::seq_play) begin
      state_next.dac = tpslc_scaled(tpslc_sample(state_reg.tpl[1:0], state_reg.idx),
                                    state_reg.scale, state_reg.tpl[1:0]);
    end else begin
      state_next.dac = 11'h000;
    end
    // Power-down from the register bit or the pattern pins
    if (hw_s) begin
      state_next.pwr_dn = (patt_s == `TPSLC_PATT_PWRDN);
    end else begin
      state_next.pwr_dn = tx_power_off_bit;
    end
    // Termination selection
    if (hw_s) begin
      state_next.term_int = !(term_pin_s && !t1j1_mode);
      state_next.rx_ext = term_pin_s;
      state_next.term_imp = tpslc_imp(tpl_now);
      state_next.cfg_err = 1'b0;
    end else begin
      state_next.term_int = !tx_term_select[`TPSLC_TERM_EXT_BIT];
      state_next.rx_ext = 1'b0;
      state_next.term_imp = tx_term_select[1:0];
      state_next.cfg_err = tx_term_select[`TPSLC_TERM_EXT_BIT] && t1j1_mode;
    end
    // Post-reset float window
    if (state_reg.hold != 5'h00) begin
      state_next.hold = state_reg.hold - 5'h01;
    end
    // Software reset restarts the float window and the scale
    if (sw_reset) begin
      state_next.hold = HOLD_CYC;
      state_next.seq = tpslc_pkg::seq_idle;
      state_next.dac = 11'h000;
      state_next.scale = is_lbo ? tpslc_def_scale(tpl_now[1:0]) : `TPSLC_SCALE_0DB;
    end
    state_next.oe = !float_req;
  end

  // State register; outputs float from reset until the hold window ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.scale <= `TPSLC_SCALE_0DB;
      state_reg.tpl <= `TPSLC_TPL_RESET;
      state_reg.hold <= HOLD_CYC;
      state_reg.term_int <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign amplitude_scale = state_reg.scale;
  assign active_template = state_reg.tpl;
  assign lbo_active = (state_reg.seq == tpslc_pkg::seq_play);
  assign dac_code = state_reg.dac;
  assign tx_line_oe = state_reg.oe;
  assign tx_power_down = state_reg.pwr_dn;
  assign tx_term_internal = state_reg.term_int;
  assign tx_term_impedance = state_reg.term_imp;
  assign rx_term_external = state_reg.rx_ext;
  assign term_config_error = state_reg.cfg_err;

endmodule
`default_nettype wire

// ### testbench/tpslc_line_model.sv
// Line transformer and cable model driven by the transmit line outputs
`default_nettype none
module tpslc_line_model (
  input wire logic clk,
  input wire logic [10:0] dac_code,
  input wire logic tx_line_oe,
  output logic [10:0] line_level
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line_level = 11'h000;
  // Driven line follows the converter; a floating line wanders
  always @(posedge clk) begin
    if (tx_line_oe) begin
      line_level <= dac_code;
    end else begin
      line_level <= ~line_level;
    end
  end
endmodule
`default_nettype wire

// ### testbench/tpslc_props.sv
// Concurrent checks on the transmit pulse shaper ports
`default_nettype none
module tpslc_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hw_mode,
  input wire logic tx_high_impedance,
  input wire logic chan_hiz_bit,
  input wire logic scale_write,
  input wire logic [5:0] scale_wdata,
  input wire logic sw_reset,
  input wire logic remote_loopback,
  input wire logic pattern_from_mclk,
  input wire logic pulse_start,
  input wire logic [3:0] pulse_template_select,
  input wire logic [5:0] amplitude_scale,
  input wire logic [3:0] active_template,
  input wire logic lbo_active,
  input wire logic [10:0] dac_code,
  input wire logic tx_line_oe,
  input wire logic tx_power_down,
  input wire logic mclk_lost,
  input wire logic tclk_lost
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Scale writes, reloads, the idle converter and playback start
  a_scale_write: assert property (
    scale_write && !sw_reset |=> amplitude_scale == $past(scale_wdata))
    else $error("scale write not loaded");
  a_reset_scale: assert property (
    sw_reset && !hw_mode && active_template == 4'h8 && $stable(pulse_template_select)
    |=> amplitude_scale == 6'h36) else $error("scale not reloaded");
  a_idle_dac: assert property (
    !lbo_active ##1 !lbo_active |-> dac_code == 11'h000) else $error("dac not idle");
  a_start_play: assert property (
    pulse_start && !sw_reset && !hw_mode && $stable(pulse_template_select) &&
    active_template[3:2] == 2'h2 |=> lbo_active) else $error("no play");
  a_refuse_play: assert property (
    pulse_start && !lbo_active && !hw_mode && $stable(pulse_template_select) &&
    active_template[3:2] != 2'h2 |=> !lbo_active) else $error("play on wrong template");
  // Conditions that float the line
  a_power_float: assert property (
    tx_power_down |-> !tx_line_oe) else $error("powered down but driving");
  a_global_hiz: assert property (
    tx_high_impedance [*4] |-> !tx_line_oe) else $error("global float ignored");
  a_chan_hiz: assert property (
    (!hw_mode) [*3] ##0 chan_hiz_bit |=> !tx_line_oe) else $error("channel float ignored");
  a_mclk_float: assert property (
    mclk_lost [*2] |-> !tx_line_oe) else $error("driving without master clock");
  a_tclk_float: assert property (
    (tclk_lost && !remote_loopback && !pattern_from_mclk) [*2] |-> !tx_line_oe)
    else $error("driving without transmit clock");
  a_swreset_hold: assert property (
    sw_reset |=> (!tx_line_oe) [*8]) else $error("line driven after soft reset");
  cover property (pulse_start ##1 lbo_active);
  cover property ($rose(mclk_lost));
  cover property ($rose(tx_power_down));
endmodule
bind tpslc_top tpslc_props u_props (.clk, .rst_n, .hw_mode, .tx_high_impedance,
  .chan_hiz_bit, .scale_write, .scale_wdata, .sw_reset, .remote_loopback,
  .pattern_from_mclk, .pulse_start, .pulse_template_select, .amplitude_scale,
  .active_template, .lbo_active, .dac_code, .tx_line_oe, .tx_power_down, .mclk_lost,
  .tclk_lost);
`default_nettype wire

// ### testbench/tb_tx_pulse_shaper_line_ctrl.sv
// Self-checking bench for the transmit pulse shaper and line control
`default_nettype none
module tb_tx_pulse_shaper_line_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, hw_mode = 0, tx_high_impedance = 0, termination_mode_pin = 0;
  logic [1:0] pattern_select_pins = 2'h0, tx_term_impedance;
  logic [3:0] pulse_template_pins = 4'h8, pulse_template_select = 4'h8, active_template;
  logic mclk_in = 0, tx_clock_in = 0, chan_hiz_bit = 0, tx_power_off_bit = 0;
  logic [2:0] tx_term_select = 3'h0;
  logic scale_write = 0, sw_reset = 0, remote_loopback = 0, pattern_from_mclk = 0;
  logic [5:0] scale_wdata = 6'h00, amplitude_scale;
  logic pulse_start = 0, sample_tick = 0, lbo_active, tx_line_oe, tx_power_down;
  logic tx_term_internal, rx_term_external, term_config_error, mclk_lost, tclk_lost;
  logic mclk_en = 1, tclk_en = 1;
  logic [10:0] dac_code, line_level;
  int errors = 0, comparisons = 0;

  tpslc_top DUT (.clk, .rst_n, .hw_mode, .tx_high_impedance, .termination_mode_pin,
    .pattern_select_pins, .pulse_template_pins, .mclk_in, .tx_clock_in,
    .pulse_template_select, .tx_term_select, .chan_hiz_bit, .tx_power_off_bit, .scale_write,
    .scale_wdata, .sw_reset, .remote_loopback, .pattern_from_mclk, .pulse_start,
    .sample_tick, .amplitude_scale, .active_template, .lbo_active, .dac_code, .tx_line_oe,
    .tx_power_down, .tx_term_internal, .tx_term_impedance, .rx_term_external,
    .term_config_error, .mclk_lost, .tclk_lost);
  tpslc_line_model u_line (.clk, .dac_code, .tx_line_oe, .line_level);

  // System clock and the two line clocks, which toggle unless stopped
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    #2;
    if (mclk_en) mclk_in = ~mclk_in;
    if (tclk_en) tx_clock_in = ~tx_clock_in;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic chk(input string what, input logic [10:0] e, input logic [10:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, e, g);
    end
  endtask

  // Bounded wait for the line to be driven again
  task automatic wait_oe;
    int i;
    for (i = 0; i < 40 && tx_line_oe !== 1'b1; i++) cyc(1);
    chk("line driven", 1, tx_line_oe);
    if (tx_line_oe !== 1'b1) tally_and_finish();
  endtask

  // Start a pulse, advance k samples, compare converter and line
  task automatic play(input logic [3:0] t, input logic [5:0] s, input int k,
                      input logic [10:0] e);
    pulse_template_select = t;
    cyc(3);
    scale_wdata = s;
    scale_write = 1;
    cyc(1);
    scale_write = 0;
    pulse_start = 1;
    cyc(1);
    pulse_start = 0;
    repeat (k) begin
      sample_tick = 1;
      cyc(1);
    end
    sample_tick = 0;
    cyc(3);
    chk("playing", 1, lbo_active);
    chk("dac", e, dac_code);
    chk("line", e, line_level);
  endtask

  task automatic t_templates;
    logic [3:0] tpl[4] = '{4'h9, 4'hA, 4'hB, 4'h8};
    logic [5:0] dflt[4] = '{6'h11, 6'h08, 6'h04, 6'h36};
    for (int i = 0; i < 4; i++) begin
      pulse_template_select = tpl[i];
      cyc(3);
      chk("template", tpl[i], active_template);
      chk("default scale", dflt[i], amplitude_scale);
    end
    for (int c = 0; c < 8; c++) begin
      pulse_template_select = c[3:0];
      cyc(2);
      pulse_start = 1;
      cyc(1);
      pulse_start = 0;
      cyc(1);
      chk("refused play", 0, lbo_active);
    end
  endtask

  task automatic t_play_end;
    play(4'h8, 6'h36, 0, 11'h017);
    sample_tick = 1;
    cyc(64);
    sample_tick = 0;
    cyc(3);
    chk("play ended", 0, lbo_active);
    chk("dac idle", 0, dac_code);
  endtask

  task automatic t_power;
    tx_power_off_bit = 1;
    cyc(1);
    chk("power down", 1, tx_power_down);
    chk("float", 0, tx_line_oe);
    tx_power_off_bit = 0;
    wait_oe();
    chan_hiz_bit = 1;
    cyc(1);
    chk("chan float", 0, tx_line_oe);
    chan_hiz_bit = 0;
    wait_oe();
    tx_high_impedance = 1;
    cyc(3);
    chk("global float", 0, tx_line_oe);
    tx_high_impedance = 0;
    wait_oe();
    hw_mode = 1;
    pattern_select_pins = 2'h3;
    cyc(4);
    chk("pin power down", 1, tx_power_down);
    pattern_select_pins = 2'h0;
    hw_mode = 0;
    wait_oe();
  endtask

  task automatic t_term;
    for (int i = 0; i < 4; i++) begin
      tx_term_select = i[2:0];
      cyc(1);
      chk("internal", 1, tx_term_internal);
      chk("impedance", i[1:0], tx_term_impedance);
    end
    pulse_template_select = 4'h0;
    tx_term_select = 3'h4;
    cyc(2);
    chk("external", 0, tx_term_internal);
    chk("no error", 0, term_config_error);
    pulse_template_select = 4'h2;
    cyc(2);
    chk("t1 external", 1, term_config_error);
    hw_mode = 1;
    pulse_template_pins = 4'h0;
    cyc(4);
    chk("hw internal", 1, tx_term_internal);
    termination_mode_pin = 1;
    cyc(4);
    chk("hw e1 ext", 0, tx_term_internal);
    chk("hw rx ext", 1, rx_term_external);
    pulse_template_pins = 4'h2;
    cyc(4);
    chk("hw t1 int", 1, tx_term_internal);
    chk("hw t1 imp", 2, tx_term_impedance);
    chk("hw t1 rx", 1, rx_term_external);
    pulse_template_pins = 4'h7;
    cyc(4);
    chk("hw j1 imp", 3, tx_term_impedance);
    termination_mode_pin = 0;
    pulse_template_pins = 4'h8;
    hw_mode = 0;
    tx_term_select = 3'h0;
    pulse_template_select = 4'h8;
    cyc(4);
  endtask

  task automatic t_clocks;
    mclk_en = 0;
    cyc(140);
    chk("mclk lost", 1, mclk_lost);
    chk("mclk float", 0, tx_line_oe);
    mclk_en = 1;
    cyc(6);
    chk("mclk back", 0, mclk_lost);
    wait_oe();
    remote_loopback = 1;
    tclk_en = 0;
    cyc(140);
    chk("tclk lost", 1, tclk_lost);
    chk("loopback drives", 1, tx_line_oe);
    remote_loopback = 0;
    pattern_from_mclk = 1;
    cyc(3);
    chk("pattern drives", 1, tx_line_oe);
    pattern_from_mclk = 0;
    cyc(3);
    chk("tclk float", 0, tx_line_oe);
    tclk_en = 1;
    wait_oe();
  endtask

  task automatic t_swreset;
    pulse_template_select = 4'h8;
    scale_wdata = 6'h20;
    scale_write = 1;
    cyc(1);
    scale_write = 0;
    sw_reset = 1;
    cyc(1);
    sw_reset = 0;
    chk("reset float", 0, tx_line_oe);
    chk("reset scale", 6'h36, amplitude_scale);
    cyc(14);
    chk("reset hold", 0, tx_line_oe);
    wait_oe();
  endtask

  initial begin
    cyc(8);
    chk("rst scale", 6'h36, amplitude_scale);
    chk("rst template", 4'h8, active_template);
    chk("rst float", 0, tx_line_oe);
    rst_n = 1;
    cyc(2);
    chk("hold float", 0, tx_line_oe);
    wait_oe();
    t_templates();
    play(4'h8, 6'h36, 16, 11'h042);
    play(4'h8, 6'h36, 17, 11'h041);
    play(4'h8, 6'h1B, 0, 11'h00B);
    play(4'h9, 6'h11, 16, 11'h014);
    play(4'h9, 6'h11, 9, 11'h03A);
    play(4'h9, 6'h11, 48, 11'h000);
    play(4'h9, 6'h12, 16, 11'h015);
    play(4'hA, 6'h08, 16, 11'h035);
    play(4'hA, 6'h08, 32, 11'h00F);
    play(4'hA, 6'h08, 48, 11'h003);
    play(4'hA, 6'h09, 16, 11'h03B);
    play(4'hB, 6'h04, 16, 11'h02C);
    play(4'hB, 6'h04, 21, 11'h032);
    play(4'hB, 6'h04, 48, 11'h008);
    play(4'hB, 6'h05, 16, 11'h037);
    t_play_end();
    t_power();
    t_term();
    t_clocks();
    t_swreset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
